/* File: rtl/pss_pkg.sv */
/*
 * pss_pkg: constants and carrier types for the program sequencer and return stack.
 * Assumes a single system clock; no software-visible bus registers.
 */
package pss_pkg;
    localparam int PC_W = 11;                  // 2K word program space
    localparam int IW_W = 15;                  // program word width
    localparam int LOW_W = 8;                  // low byte of counter
    localparam int STK_DEPTH = 4;              // return stack levels
    localparam int SIDX_W = 2;
    localparam logic [SIDX_W-1:0] SIDX_TOP = 2'h0;   // top of stack after reset
    localparam logic [PC_W-1:0] VEC_RESET = 11'h000;
    localparam logic [PC_W-1:0] VEC_TIMER = 11'h008;
    localparam logic [PC_W-1:0] PC_ONE = 11'h001;
    localparam logic [2:0] STK_FULL_CNT = 3'h4;
    localparam logic [2:0] STK_CNT_ONE = 3'h1;
    localparam logic [2:0] STK_CNT_ZERO = 3'h0;
    localparam logic [7:0] ALU_CARRY_BIT = 8'h00;

    // phase of the instruction cycle
    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} pss_phase_t;

    // flow request given by decode, sampled at the end of T4
    typedef struct packed {
        logic skip;                    // conditional skip met
        logic low_wr;                  // write to pc_low_byte
        logic [LOW_W-1:0] low_data;    // value written
        logic jump;                    // jump_op
        logic call;                    // subroutine_call_op
        logic ret;                     // return_op or return_from_isr_op
        logic [PC_W-1:0] target;       // instruction address bits
    } pss_flow_t;

    // alu result and status from the datapath
    typedef struct packed {
        logic wr;
        logic [LOW_W-1:0] result;
        logic [3:0] flags;             // carry, aux carry, zero, overflow
    } pss_alu_t;
endpackage : pss_pkg

/* File: rtl/pss_sequencer.sv */
/*
 * pss_sequencer: four-phase instruction cycle, program counter update modes,
 * four-level return stack and interrupt acknowledge gating.
 * Assumes decode holds flow and alu inputs steady for the instruction cycle.
 */
//Behaviour
//- four phases make one instruction cycle
//- counter advances at start of first phase
//- fetch overlaps execute; branches take two cycles
//- counter increments by one per instruction
//- low byte write jumps within page
//- met skip discards prefetch, dummy cycle
//- jumps and calls load instruction address
//- four-level return stack, hidden from software
//- call or interrupt pushes, return pops
//- reset points stack index at top
//- stack full holds interrupt until return
//- call on full stack overflows anyway
//- alu result and status written back
//- counter addresses 2K by 15 memory
//- reset loads vector 000H
//- timer overflow vectors to 008H
`timescale 1ns/1ns
module pss_sequencer
    import pss_pkg::*;
(
    input wire logic sys_clk,                  // 50 MHz system clock
    input wire logic rst_n,                    // async reset, active low
    input wire logic clk_en,                   // freezes all state when low
    input wire pss_flow_t flow_in,             // decode flow request
    input wire pss_alu_t alu_in,               // alu result and flags
    input wire logic timer_ovf,                // timer overflow pulse
    input wire logic timer_int_en,             // timer interrupt enable
    input wire logic [IW_W-1:0] pmem_data,     // program memory word
    output logic [PC_W-1:0] pmem_addr,         // program memory address
    output logic [IW_W-1:0] instr_q,           // instruction being executed
    output logic instr_valid_q,                // instr_q is real, not dummy
    output pss_phase_t phase_q,                // current phase
    output logic [LOW_W-1:0] pc_low_byte_q,    // readable low byte of counter
    output logic int_ack_q,                    // interrupt acknowledge pulse
    output logic [LOW_W-1:0] alu_reg_q,        // result register
    output logic [3:0] status_q                // status flags
);
    // program counter and its derived values
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] page_target;

    // return stack storage, index and fill level
    logic [PC_W-1:0] stack_q [STK_DEPTH];
    logic [SIDX_W-1:0] stack_index_q;
    logic [SIDX_W-1:0] pop_idx;
    logic [SIDX_W-1:0] push_idx;
    logic [STK_DEPTH-1:0] push_sel;
    logic [2:0] depth_q;
    logic push_en;
    logic pop_en;
    logic stk_full;
    logic stk_empty;

    // cycle control and interrupt gating
    pss_phase_t phase_d;
    logic cycle_end;
    logic dummy_q;
    logic flow_live;
    logic branch;
    logic redirect;
    logic int_pend_q;
    logic int_req;
    logic take_int;
    logic alu_take;

    // source of the next counter value
    typedef enum logic [2:0] {
        SRC_INC,
        SRC_VEC,
        SRC_POP,
        SRC_BRANCH,
        SRC_PAGE,
        SRC_SKIP
    } pss_src_t;
    pss_src_t pc_src;

    // a dummy cycle carries no instruction, so its flow request is ignored
    assign cycle_end = clk_en && (phase_q == PH_T4);
    assign flow_live = !dummy_q;
    assign branch = flow_in.jump || flow_in.call;
    assign redirect = flow_live && (flow_in.skip || flow_in.low_wr || branch || flow_in.ret);

    // stack level flags
    assign stk_full = (depth_q == STK_FULL_CNT);
    assign stk_empty = (depth_q == STK_CNT_ZERO);

    // a full stack withholds the interrupt; it also waits out an
    // instruction that redirects, so that instruction's target is not lost
    assign int_req = int_pend_q && !stk_full;
    assign take_int = int_req && flow_live && !redirect;

    // push on call or acknowledge, pop on either return
    assign push_en = take_int || (flow_live && flow_in.call);
    assign pop_en = !take_int && flow_live && flow_in.ret;
    assign push_idx = stack_index_q;
    assign pop_idx = stack_index_q - 2'h1;

    // counter arithmetic shared by several sources
    assign pc_inc = pc_q + PC_ONE;
    assign page_target = {pc_q[PC_W-1:LOW_W], flow_in.low_data};
    assign alu_take = cycle_end && alu_in.wr && flow_live;

    // next phase: T1 to T4 repeat
    always_comb begin
        case (phase_q)
            PH_T1: phase_d = PH_T2;
            PH_T2: phase_d = PH_T3;
            PH_T3: phase_d = PH_T4;
            PH_T4: phase_d = PH_T1;
            default: phase_d = PH_T1;
        endcase
    end

    // phase register; a low enable freezes the cycle mid-phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_T1;
        end else if (clk_en) begin
            phase_q <= phase_d;
        end
    end

    // pick the source of the next counter value; the prefetched word is at pc_q
    always_comb begin
        pc_src = SRC_INC;
        if (take_int) begin
            pc_src = SRC_VEC;
        end else if (flow_live) begin
            if (flow_in.ret) begin
                pc_src = SRC_POP;
            end else if (branch) begin
                pc_src = SRC_BRANCH;
            end else if (flow_in.low_wr) begin
                pc_src = SRC_PAGE;
            end else if (flow_in.skip) begin
                pc_src = SRC_SKIP;
            end
        end
    end

    // next counter value for each source
    always_comb begin
        case (pc_src)
            SRC_INC: pc_d = pc_inc;
            SRC_VEC: pc_d = VEC_TIMER;
            SRC_POP: pc_d = stack_q[pop_idx];
            SRC_BRANCH: pc_d = flow_in.target;
            SRC_PAGE: pc_d = page_target;
            // the discarded prefetch already used up one count
            SRC_SKIP: pc_d = pc_inc;
            default: pc_d = pc_inc;
        endcase
    end

    // program counter, updated at the T4/T1 boundary
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= VEC_RESET;
        end else if (cycle_end) begin
            pc_q <= pc_d;
        end
    end

    // fetch overlaps execute: the word taken now runs in the next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_q <= '0;
        end else if (cycle_end) begin
            instr_q <= pmem_data;
        end
    end

    // a redirect turns the prefetched word into a dummy cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dummy_q <= 1'b1;
        end else if (cycle_end) begin
            dummy_q <= redirect || take_int;
        end
    end

    // valid flag is the inverse of dummy, kept as its own output flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_valid_q <= 1'b0;
        end else if (cycle_end) begin
            instr_valid_q <= !(redirect || take_int);
        end
    end

    // fetch address out of a flop, following the counter's next value
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pmem_addr <= VEC_RESET;
        end else if (cycle_end) begin
            pmem_addr <= pc_d;
        end
    end

    // readable low byte of the counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_low_byte_q <= '0;
        end else if (cycle_end) begin
            pc_low_byte_q <= pc_d[LOW_W-1:0];
        end
    end

    // one-hot select of the entry a push lands in
    always_comb begin
        push_sel = '0;
        push_sel[push_idx] = push_en;
    end

    // stack entries; circular, so a call on a full stack overwrites the
    // oldest entry, which the hardware does not guard against
    for (genvar g = 0; g < STK_DEPTH; g++) begin : g_entry
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                stack_q[g] <= VEC_RESET;
            end else if (cycle_end && push_sel[g]) begin
                // interrupt and call both resume at the prefetched word, the value in pc_q
                stack_q[g] <= pc_q;
            end
        end
    end

    // stack index: up on push, down on pop, wrapping on overflow
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_index_q <= SIDX_TOP;
        end else if (cycle_end) begin
            if (push_en) begin
                stack_index_q <= push_idx + 2'h1;
            end else if (pop_en) begin
                stack_index_q <= pop_idx;
            end
        end
    end

    // fill level saturates, so full stays seen after an overflowing call
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_q <= STK_CNT_ZERO;
        end else if (cycle_end) begin
            if (push_en && !stk_full) begin
                depth_q <= depth_q + STK_CNT_ONE;
            end else if (pop_en && !stk_empty) begin
                depth_q <= depth_q - STK_CNT_ONE;
            end
        end
    end

    // request latch; a new overflow wins over the acknowledge clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (timer_ovf && timer_int_en) begin
                int_pend_q <= 1'b1;
            end else if (cycle_end && take_int) begin
                int_pend_q <= 1'b0;
            end
        end
    end

    // acknowledge pulse, one clock wide as the vector fetch starts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ack_q <= 1'b0;
        end else if (clk_en) begin
            int_ack_q <= cycle_end && take_int;
        end
    end

    // alu result register; a dummy cycle writes nothing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alu_reg_q <= ALU_CARRY_BIT;
        end else if (alu_take) begin
            alu_reg_q <= alu_in.result;
        end
    end

    // status flags follow the same write as the result
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else if (alu_take) begin
            status_q <= alu_in.flags;
        end
    end
endmodule : pss_sequencer

/* File: tb/pss_sequencer_checker.sv */
/* pss_sequencer_checker: flow assertions on the sequencer ports.
   bound from the bench top; one clock domain. */
`timescale 1ns/1ns
module pss_sequencer_checker
    import pss_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire logic clk_en, // enable
    input wire pss_flow_t flow_in, // flow
    input wire pss_alu_t alu_in, // alu
    input wire logic timer_int_en, // irq on
    input wire logic [IW_W-1:0] pmem_data, // word
    input wire logic [PC_W-1:0] pmem_addr, // fetch
    input wire logic [IW_W-1:0] instr_q, // exec
    input wire logic instr_valid_q, // real
    input wire pss_phase_t phase_q, // phase
    input wire logic [LOW_W-1:0] pc_low_byte_q, // low
    input wire logic int_ack_q, // ack
    input wire logic [LOW_W-1:0] alu_reg_q, // result
    input wire logic [3:0] status_q // flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // cycle end; interrupts kept out so flow requests decide alone
    wire logic ce = clk_en && phase_q == PH_T4;
    wire logic q = ce && instr_valid_q && !timer_int_en;
    wire logic lw = q && !flow_in.jump && !flow_in.call && !flow_in.ret;
    property p_wrap; ce |=> phase_q == PH_T1; endproperty
    a_wrap: assert property (p_wrap) else $error("phase did not wrap");
    property p_hold; (clk_en && phase_q != PH_T4) |=> $stable(pmem_addr) && $stable(instr_q); endproperty
    a_hold: assert property (p_hold) else $error("fetch moved mid cycle");
    property p_inc; (ce && !timer_int_en && (!instr_valid_q || flow_in == '0)) |=>
        pmem_addr == $past(pmem_addr) + PC_ONE && instr_valid_q && instr_q == $past(pmem_data); endproperty
    a_inc: assert property (p_inc) else $error("no plain increment");
    property p_jump; (q && flow_in.jump) |=> pmem_addr == $past(flow_in.target) && !instr_valid_q; endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_low; (lw && flow_in.low_wr) |=> pc_low_byte_q == $past(flow_in.low_data) &&
        pmem_addr[PC_W-1:LOW_W] == $past(pmem_addr[PC_W-1:LOW_W]) && !instr_valid_q; endproperty
    a_low: assert property (p_low) else $error("low byte load wrong");
    property p_skip; (lw && !flow_in.low_wr && flow_in.skip) |=>
        pmem_addr == $past(pmem_addr) + PC_ONE && !instr_valid_q; endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_ack; int_ack_q |-> pmem_addr == VEC_TIMER && !instr_valid_q ##1 !int_ack_q; endproperty
    a_ack: assert property (p_ack) else $error("acknowledge wrong");
    property p_alu; (q && alu_in.wr) |=> alu_reg_q == $past(alu_in.result) &&
        status_q == $past(alu_in.flags); endproperty
    a_alu: assert property (p_alu) else $error("alu write back wrong");
    c_jump: cover property (q && flow_in.jump);
    c_skip: cover property (lw && flow_in.skip);
    c_ack: cover property (int_ack_q);
endmodule : pss_sequencer_checker

/* File: tb/pss_sequencer_tb_top.sv */
/* pss_sequencer_tb_top: directed flow scenarios for the sequencer.
   program memory modelled combinationally as word = address. */
`timescale 1ns/1ns
module pss_sequencer_tb_top
    import pss_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic timer_ovf = 1'b0;
    logic timer_int_en = 1'b0;
    pss_flow_t flow_in = '0;
    pss_alu_t alu_in = '0;
    logic [PC_W-1:0] pmem_addr;
    logic [IW_W-1:0] instr_q;
    logic instr_valid_q;
    logic int_ack_q;
    pss_phase_t phase_q;
    logic [LOW_W-1:0] pc_low_byte_q;
    logic [LOW_W-1:0] alu_reg_q;
    logic [3:0] status_q;
    int err_count = 0;
    int checks_done = 0;
    always #10 sys_clk = ~sys_clk;
    pss_sequencer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .flow_in(flow_in),
        .alu_in(alu_in), .timer_ovf(timer_ovf), .timer_int_en(timer_int_en),
        .pmem_data({4'h0, pmem_addr}), .pmem_addr(pmem_addr), .instr_q(instr_q),
        .instr_valid_q(instr_valid_q), .phase_q(phase_q), .pc_low_byte_q(pc_low_byte_q),
        .int_ack_q(int_ack_q), .alu_reg_q(alu_reg_q), .status_q(status_q));
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // valid bit over fetch address
    task automatic ex(input logic [11:0] e);
        chk({instr_valid_q, pmem_addr}, e);
    endtask : ex
    // one instruction cycle; inputs held until the T4 edge takes them
    task automatic cyc(input pss_flow_t f, input logic [1:0] t = 2'h0, input pss_alu_t a = '0);
        int n;
        @(posedge sys_clk);
        flow_in <= f;
        alu_in <= a;
        {timer_int_en, timer_ovf} <= t;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (phase_q !== PH_T4 && n < 8);
        if (n >= 8) begin
            err_count++;
            stop_test();
        end
        #1;
    endtask : cyc
    function automatic pss_flow_t fl(input logic [4:0] k, input logic [10:0] a);
        return '{k[4], k[3], a[7:0], k[2], k[1], k[0], a};
    endfunction : fl
    // reset release then the documented flow modes in order
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        ex(12'h000);
        cyc('0);
        chk(instr_q, 15'h0000);
        ex(12'h801);
        cyc(fl(5'h04, 11'h345), 2'h0, '{1'b1, 8'ha5, 4'h9});
        ex(12'h345);
        chk({status_q, alu_reg_q}, 12'h9a5);
        cyc('0);
        chk(instr_q, 15'h0345);
        ex(12'hb46);
        cyc(fl(5'h10, 11'h000));
        ex(12'h347);
        cyc('0);
        chk(instr_q, 15'h0347);
        cyc(fl(5'h08, 11'h010));
        ex(12'h310);
        chk(pc_low_byte_q, 8'h10);
        cyc('0);
        // four calls leave the stack full
        for (int k = 1; k < 5; k++) begin
            cyc(fl(5'h02, 11'(k * 256)));
            ex(12'(k * 256));
            cyc('0);
        end
        cyc('0, 2'h3);
        chk({int_ack_q, instr_valid_q, pmem_addr}, 13'h0c02);
        cyc(fl(5'h01, 11'h000), 2'h2);
        ex(12'h301);
        cyc('0, 2'h2);
        cyc('0, 2'h2);
        chk({int_ack_q, instr_valid_q, pmem_addr}, 13'h1008);
        cyc('0);
        cyc(fl(5'h01, 11'h000));
        ex(12'h302);
        // a low enable holds phase and outputs
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (6) @(posedge sys_clk);
        clk_en <= 1'b1;
        #1;
        chk(phase_q, PH_T2);
        ex(12'h302);
        // a call on a full stack still runs and overflows
        cyc('0);
        cyc(fl(5'h02, 11'h500));
        cyc('0);
        cyc(fl(5'h02, 11'h600));
        ex(12'h600);
        cyc('0);
        cyc(fl(5'h01, 11'h000));
        ex(12'h501);
        stop_test();
    end
endmodule : pss_sequencer_tb_top
bind pss_sequencer pss_sequencer_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .flow_in(flow_in), .alu_in(alu_in), .timer_int_en(timer_int_en),
    .pmem_data(pmem_data), .pmem_addr(pmem_addr), .instr_q(instr_q),
    .instr_valid_q(instr_valid_q), .phase_q(phase_q), .pc_low_byte_q(pc_low_byte_q),
    .int_ack_q(int_ack_q), .alu_reg_q(alu_reg_q), .status_q(status_q));
